/* verilog/ras_top.sv */
// Notes on behaviour
// - fetch above present memory returns zero
// - 31 entries of 21 bits, pointer reset
// - calls, push, interrupts push; returns pop
// - returns leave the pc latches alone
// - push increments pointer, then writes entry
// - pop reads entry, then decrements pointer
// - pointer zero has no storage entry
// - three byte registers access top entry
// - software reads and writes pointer 0-31
// - full flag after 31 pushes
// - fault reset on: pc+2, flag, reset
// - fault reset off: pointer sticks at 31
// - empty pop: pc zero, underflow flag
// - flag first, reset only if enabled
// - flags cleared by software or power-on only
// - full bit7, underflow bit6, pointer bits4-0
// - push instruction stores pc, flow unchanged
// - pop instruction drops top, pc unchanged
// - shadow loaded on interrupt, not software visible
// - fast return restores shadow values
// - every interrupt priority overwrites shadow
// - fast call loads shadow
module ras_top #(
  parameter int unsigned PM_BYTES = ras_pkg::RAS_PM_BYTES  // bytes of program memory present
) (
  input  wire logic               clock,
  input  wire logic               rst_b,       // power-on reset
  input  wire logic               sys_reset,   // any other device reset, synchronous
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  wire ras_pkg::ras_req_t  core_req,
  output ras_pkg::ras_rsp_t       core_rsp,
  input  wire ras_pkg::ras_fetch_t fetch_req,
  output logic [15:0]             fetch_word,
  output logic                    fault_reset
);
  import ras_pkg::*;

  // complete state of the block
  typedef struct packed {
    logic [31:1][20:0] entry;     // stack storage, nothing behind level zero
    logic [4:0]        level;     // stack_level
    logic              full;      // stack_full_flag
    logic              under;     // stack_underflow_flag
    logic              sfre;      // stack_fault_reset_enable
    logic [7:0]        sh_status; // fast shadow
    logic [7:0]        sh_working_register;
    logic [7:0]        sh_bsr;
    logic              dp_act;    // bus data phase pending
    logic              dp_wr;
    logic              dp_hit;    // upper address bits zero
    logic [7:0]        dp_addr;
    logic              hready;
    logic [31:0]       hrdata;
    ras_rsp_t          rsp;
    logic              fault;
    logic [15:0]       fword;
  } ras_state_t;

  // byte addresses at or above this limit have no memory behind them
  // the limit is a parameter so a larger part can reuse the block
  localparam logic [20:0] PM_LIMIT = PM_BYTES[20:0]; // first absent byte address

  ras_state_t        s;          // registered state
  ras_state_t        next_s;     // next state
  logic [20:0]       top_entry;  // entry selected by the pointer
  logic [31:0]       rd_data;    // read mux
  logic              is_push;
  logic              is_ret;
  logic              is_pop;
  logic              ptr_wr;     // software write to the pointer this cycle

  // operation classes
  always_comb begin
    is_push = (core_req.op == RAS_OP_PUSH) || (core_req.op == RAS_OP_CALL) ||
              (core_req.op == RAS_OP_RELATIVE_CALL) || (core_req.op == RAS_OP_INT_ACK);
    is_ret  = (core_req.op == RAS_OP_RETURN) || (core_req.op == RAS_OP_RETURN_WITH_LITERAL) ||
              (core_req.op == RAS_OP_RETURN_FROM_INTERRUPT);
    is_pop  = (core_req.op == RAS_OP_POP);
  end

  // top of stack view; level zero reads as zero since it has no entry
  always_comb begin
    if (s.level == RAS_LVL_EMPTY) begin
      top_entry = 21'h000000;
    end else begin
      top_entry = s.entry[s.level];
    end
  end

  // software write to the pointer in this data phase
  // a same-cycle sequencer op still overrides the level it writes, except a return or pop at level zero
  assign ptr_wr = s.dp_act && s.dp_wr && s.dp_hit && (s.dp_addr == RAS_OFF_PTR);

  // register read mux, reserved bits zero
  always_comb begin
    rd_data = 32'h00000000;
    if (s.dp_hit) begin
      case (s.dp_addr)
        RAS_OFF_PTR:  rd_data = {24'h000000, s.full, s.under, 1'b0, s.level};
        RAS_OFF_TOP_ENTRY_LOW: rd_data = {24'h000000, top_entry[7:0]};
        RAS_OFF_TOP_ENTRY_HIGH: rd_data = {24'h000000, top_entry[15:8]};
        RAS_OFF_TOP_ENTRY_UPPER: rd_data = {27'h0000000, top_entry[20:16]};
        RAS_OFF_CFG:  rd_data = {31'h00000000, s.sfre};
        default:      rd_data = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // next state: bus access first, then the sequencer, then other resets
  always_comb begin
    next_s = s;
    next_s.rsp.pc_valid      = 1'b0;
    next_s.rsp.restore_valid = 1'b0;
    next_s.fault             = 1'b0;

    // fetch path, unimplemented space executes as a no-operation
    next_s.fword = 16'h0000;
    if (fetch_req.valid && (fetch_req.addr < PM_LIMIT)) begin
      next_s.fword = fetch_req.word;
    end

    // data phase of an earlier bus transfer
    if (s.dp_act) begin
      next_s.dp_act = 1'b0;
      if (!s.dp_wr) begin
        next_s.hrdata = rd_data; // read answer after one wait state
        next_s.hready = 1'b1;
      end else if (s.dp_hit) begin
        case (s.dp_addr)
          RAS_OFF_PTR: begin
            next_s.level = hwdata[4:0];
            // flags only clear on a written zero, ones are ignored
            if (!hwdata[RAS_FULL_BIT]) begin
              next_s.full = 1'b0;
            end
            if (!hwdata[RAS_UNDER_BIT]) begin
              next_s.under = 1'b0;
            end
          end
          RAS_OFF_TOP_ENTRY_LOW: begin
            if (s.level != RAS_LVL_EMPTY) begin
              next_s.entry[s.level][7:0] = hwdata[7:0];
            end
          end
          RAS_OFF_TOP_ENTRY_HIGH: begin
            if (s.level != RAS_LVL_EMPTY) begin
              next_s.entry[s.level][15:8] = hwdata[7:0];
            end
          end
          RAS_OFF_TOP_ENTRY_UPPER: begin
            if (s.level != RAS_LVL_EMPTY) begin
              next_s.entry[s.level][20:16] = hwdata[4:0];
            end
          end
          RAS_OFF_CFG: next_s.sfre = hwdata[RAS_CFG_SFRE];
          default: next_s.sfre = next_s.sfre; // unmapped writes ignored
        endcase
      end
    end

    // address phase; reads take one wait state so hrdata can come from a flop
    if (hsel && hready && ((htrans == RAS_HTRANS_NSEQ) || (htrans == RAS_HTRANS_SEQ))) begin
      next_s.dp_act  = 1'b1;
      next_s.dp_wr   = hwrite;
      next_s.dp_hit  = (haddr[31:8] == 24'h000000);
      next_s.dp_addr = haddr[7:0];
      next_s.hready  = hwrite;
    end

    // sequencer operation; applied after the bus so a flag set wins over a clear
    if (!sys_reset) begin
      if (is_push) begin
        if (s.level >= RAS_LVL_FULL) begin
          next_s.full = 1'b1;
          if (s.sfre) begin
            next_s.entry[RAS_LVL_TOP] = core_req.pc + RAS_FAULT_INC;
            next_s.level              = RAS_LVL_EMPTY;
            next_s.fault              = 1'b1;
          end else begin
            next_s.entry[RAS_LVL_TOP] = core_req.pc;
            next_s.level              = RAS_LVL_TOP;
          end
        end else begin
          // increment first, then store into the new slot; no pc change for push
          next_s.level = s.level + RAS_LVL_STEP;
          next_s.entry[s.level + RAS_LVL_STEP] = core_req.pc;
        end
        // interrupts of either priority and fast calls fill the shadow
        if ((core_req.op == RAS_OP_INT_ACK) || ((core_req.op == RAS_OP_CALL) && core_req.fast)) begin
          next_s.sh_status = core_req.status;
          next_s.sh_working_register   = core_req.working_register;
          next_s.sh_bsr    = core_req.bank_select_register;
        end
      end else if (is_ret || is_pop) begin
        if (s.level == RAS_LVL_EMPTY) begin
          next_s.under = 1'b1;
          next_s.fault = s.sfre;
          if (is_ret) begin
            next_s.rsp.pc_valid = 1'b1;
            next_s.rsp.pc       = 21'h000000;
          end
        end else begin
          // read before decrement; pop instruction gives no pc
          if (is_ret) begin
            next_s.rsp.pc_valid = 1'b1;
            next_s.rsp.pc       = top_entry;
          end
          next_s.level = s.level - RAS_LVL_STEP;
        end
        if (is_ret && core_req.fast && (core_req.op != RAS_OP_RETURN_WITH_LITERAL)) begin
          next_s.rsp.restore_valid = 1'b1;
          next_s.rsp.status        = s.sh_status;
          next_s.rsp.working_register          = s.sh_working_register;
          next_s.rsp.bank_select_register           = s.sh_bsr;
        end
      end
    end else begin
      // other resets clear the pointer but keep the sticky flags
      next_s.level = RAS_LVL_RST;
    end
  end

  // state register; power-on clears everything except the fault reset enable and hready, which load one
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s        <= '0;
      s.sfre   <= RAS_SFRE_RST;
      s.hready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  // every answer is registered, so timing to the core stays one flop deep
  // hresp has no error case: unmapped space simply reads zero
  assign hreadyout   = s.hready;
  assign hrdata      = s.hrdata;
  assign hresp       = 1'b0;
  assign core_rsp    = s.rsp;
  assign fetch_word  = s.fword;
  assign fault_reset = s.fault;

  // ---- checks ----
  chk_push_incr: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_push && (s.level < RAS_LVL_FULL)) |=> (s.level == $past(s.level) + RAS_LVL_STEP))
    else $error("push did not raise the pointer by one");

  chk_push_store: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_push && (s.level < RAS_LVL_FULL) && !(s.dp_act && s.dp_wr))
      |=> (top_entry == $past(core_req.pc)))
    else $error("pushed pc not found at the new top");

  chk_pop_load: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_ret && (s.level != RAS_LVL_EMPTY) && !ptr_wr)
      |=> (core_rsp.pc_valid && (core_rsp.pc == $past(top_entry)) && (s.level == $past(s.level) - RAS_LVL_STEP)))
    else $error("return did not load top then decrement");

  chk_under_flag: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_ret && (s.level == RAS_LVL_EMPTY) && !ptr_wr)
      |=> (core_rsp.pc_valid && (core_rsp.pc == 21'h000000) && s.under && (s.level == RAS_LVL_EMPTY)))
    else $error("empty return did not give zero and underflow");

  chk_full_reset: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_push && s.sfre && (s.level == RAS_LVL_FULL))
      |=> (fault_reset && s.full && (s.level == RAS_LVL_EMPTY)
           && (s.entry[RAS_LVL_TOP] == $past(core_req.pc) + RAS_FAULT_INC)))
    else $error("31st push with fault reset misbehaved");

  chk_full_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_push && !s.sfre && (s.level >= RAS_LVL_FULL) && !ptr_wr)
      |=> (!fault_reset && s.full && (s.level == RAS_LVL_TOP)))
    else $error("full push without fault reset misbehaved");

  chk_flag_sticky: assert property (@(posedge clock) disable iff (!rst_b)
    (s.full && !ptr_wr) |=> s.full)
    else $error("full flag cleared without software write");

  chk_fetch_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (fetch_req.valid && (fetch_req.addr >= PM_LIMIT)) |=> (fetch_word == 16'h0000))
    else $error("fetch from absent memory not zero");

  chk_shadow_load: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && (core_req.op == RAS_OP_INT_ACK))
      |=> ((s.sh_working_register == $past(core_req.working_register)) && (s.sh_status == $past(core_req.status))))
    else $error("interrupt did not load the shadow");

  chk_fast_restore: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && (core_req.op == RAS_OP_RETURN_FROM_INTERRUPT) && core_req.fast)
      |=> (core_rsp.restore_valid && (core_rsp.bank_select_register == $past(s.sh_bsr))))
    else $error("fast return did not restore shadow");

  chk_read_wait: assert property (@(posedge clock) disable iff (!rst_b)
    (hsel && hready && (htrans == RAS_HTRANS_NSEQ) && !hwrite) |=> (!hreadyout ##1 hreadyout))
    else $error("read answer timing wrong");

  // writes finish with no wait state
  chk_write_nowait: assert property (@(posedge clock) disable iff (!rst_b)
    (hsel && hready && (htrans == RAS_HTRANS_NSEQ) && hwrite) |=> hreadyout)
    else $error("write inserted a wait state");

  // pop instruction gives no pc and drops one level
  chk_pop_nopc: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_pop && (s.level != RAS_LVL_EMPTY) && !ptr_wr)
      |=> (!core_rsp.pc_valid && (s.level == $past(s.level) - RAS_LVL_STEP)))
    else $error("pop instruction misbehaved");

  // other resets clear the pointer and keep both flags
  chk_sys_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (sys_reset && !ptr_wr)
      |=> ((s.level == RAS_LVL_EMPTY) && (s.full == $past(s.full)) && (s.under == $past(s.under))))
    else $error("device reset disturbed flags or pointer");

  // underflow flag stays until software clears it
  chk_under_sticky: assert property (@(posedge clock) disable iff (!rst_b)
    (s.under && !ptr_wr) |=> s.under)
    else $error("underflow flag cleared without software write");

  // a fault reset only follows a set flag with the enable on
  chk_fault_gate: assert property (@(posedge clock) disable iff (!rst_b)
    fault_reset
      |-> ($past(s.sfre) && (s.full || s.under)))
    else $error("fault reset without enable or flag");

  // pointer read shows bit 5 and the upper bits as zero
  chk_ptr_bit5: assert property (@(posedge clock) disable iff (!rst_b)
    (s.dp_act && !s.dp_wr && s.dp_hit && (s.dp_addr == RAS_OFF_PTR))
      |=> ((hrdata[5] == 1'b0) && (hrdata[31:8] == 24'h000000)))
    else $error("pointer read shows reserved bits");

  // top entry read at level zero gives zero
  chk_empty_tos: assert property (@(posedge clock) disable iff (!rst_b)
    (s.dp_act && !s.dp_wr && s.dp_hit && (s.dp_addr == RAS_OFF_TOP_ENTRY_LOW) && (s.level == RAS_LVL_EMPTY))
      |=> (hrdata == 32'h00000000))
    else $error("top entry at level zero not zero");

  // software pointer write lands when no op competes
  chk_ptr_write: assert property (@(posedge clock) disable iff (!rst_b)
    (ptr_wr && !sys_reset && !is_push && !is_ret && !is_pop)
      |=> (s.level == $past(hwdata[4:0])))
    else $error("pointer write did not land");

  // fetch inside present memory passes the word through
  chk_fetch_pass: assert property (@(posedge clock) disable iff (!rst_b)
    (fetch_req.valid && (fetch_req.addr < PM_LIMIT))
      |=> (fetch_word == $past(fetch_req.word)))
    else $error("fetch from present memory altered");

  // fast call fills the shadow
  chk_fast_call: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && (core_req.op == RAS_OP_CALL) && core_req.fast)
      |=> ((s.sh_bsr == $past(core_req.bank_select_register)) && (s.sh_working_register == $past(core_req.working_register))))
    else $error("fast call did not load the shadow");

  // full push with the enable off stores into the top slot only
  chk_full_entry: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_push && !s.sfre && (s.level >= RAS_LVL_FULL))
      |=> (s.entry[RAS_LVL_TOP] == $past(core_req.pc)))
    else $error("full push did not overwrite the top slot");

  // ordinary push leaves the full flag alone
  chk_push_nofull: assert property (@(posedge clock) disable iff (!rst_b)
    (!sys_reset && is_push && (s.level < RAS_LVL_FULL) && !s.full && !ptr_wr)
      |=> !s.full)
    else $error("full flag set before the 31st push");

endmodule

/* shared/ras_pkg.sv */
package ras_pkg;

  // stack geometry
  localparam int unsigned RAS_PC_W       = 21;        // program counter width
  localparam int unsigned RAS_LVL_W      = 5;         // stack pointer width
  localparam int unsigned RAS_PM_BYTES   = 32768;     // program memory physically present
  localparam int unsigned RAS_WORD_W     = 16;        // instruction word width

  // pointer values with a special meaning
  localparam logic [4:0]  RAS_LVL_EMPTY  = 5'h00;     // no storage behind this value
  localparam logic [4:0]  RAS_LVL_FULL   = 5'h1e;     // next push is the 31st
  localparam logic [4:0]  RAS_LVL_TOP    = 5'h1f;     // highest entry
  localparam logic [4:0]  RAS_LVL_STEP   = 5'h01;     // pointer step
  localparam logic [20:0] RAS_FAULT_INC  = 21'h000002; // added to pc on the faulting push

  // pointer and config register field positions
  localparam int unsigned RAS_FULL_BIT   = 7;
  localparam int unsigned RAS_UNDER_BIT  = 6;
  localparam int unsigned RAS_CFG_SFRE   = 0;

  // register byte offsets
  localparam logic [7:0]  RAS_OFF_PTR    = 8'h00;     // return_stack_pointer_reg
  localparam logic [7:0]  RAS_OFF_TOP_ENTRY_LOW   = 8'h04;     // top_entry_low
  localparam logic [7:0]  RAS_OFF_TOP_ENTRY_HIGH   = 8'h08;     // top_entry_high
  localparam logic [7:0]  RAS_OFF_TOP_ENTRY_UPPER   = 8'h0c;     // top_entry_upper
  localparam logic [7:0]  RAS_OFF_CFG    = 8'h10;     // stack_fault_reset_enable

  // reset values
  localparam logic        RAS_SFRE_RST   = 1'b1;      // fault reset enabled by default
  localparam logic [4:0]  RAS_LVL_RST    = 5'h00;

  // bus transfer types
  localparam logic [1:0]  RAS_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  RAS_HTRANS_SEQ  = 2'h3;

  // sequencer operations
  typedef enum logic [3:0] {
    RAS_OP_NONE    = 4'h0,
    RAS_OP_PUSH    = 4'h1,  // push instruction
    RAS_OP_CALL    = 4'h2,
    RAS_OP_RELATIVE_CALL   = 4'h3,  // relative_call
    RAS_OP_INT_ACK = 4'h4,  // interrupt acknowledge
    RAS_OP_RETURN  = 4'h5,
    RAS_OP_RETURN_WITH_LITERAL   = 4'h6,  // return_with_literal
    RAS_OP_RETURN_FROM_INTERRUPT  = 4'h7,  // return_from_interrupt
    RAS_OP_POP     = 4'h8   // pop instruction
  } ras_op_t;

  // request from the sequencer, one cycle per operation
  typedef struct packed {
    ras_op_t     op;
    logic        fast;
    logic [20:0] pc;
    logic [7:0]  status;
    logic [7:0]  working_register;
    logic [7:0]  bank_select_register;
  } ras_req_t;

  // answer to the sequencer
  typedef struct packed {
    logic        pc_valid;
    logic [20:0] pc;
    logic        restore_valid;
    logic [7:0]  status;
    logic [7:0]  working_register;
    logic [7:0]  bank_select_register;
  } ras_rsp_t;

  // program memory fetch path
  typedef struct packed {
    logic        valid;
    logic [20:0] addr;
    logic [15:0] word;
  } ras_fetch_t;

endpackage

/* sim/ras_seq_model.sv */
// stand-in for the instruction sequencer and interrupt logic
module ras_seq_model (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              fault_reset,
  input  wire ras_pkg::ras_rsp_t core_rsp,
  output ras_pkg::ras_req_t      core_req,
  output logic                   sys_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  import ras_pkg::*;

  // idle request from time zero so the stack sees no op before reset ends
  initial core_req = '0;

  // a fault request comes back as a one-cycle device reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset <= 1'b0;
    end else begin
      sys_reset <= fault_reset;
    end
  end

  // one op for one cycle; the answer is picked up in the cycle after it is taken
  // working_register and bsr are offset from status so a swapped field shows up
  task automatic do_op(input ras_op_t op, input logic fast, input logic [20:0] pc,
                       input logic [7:0] sv, output ras_rsp_t rsp, output logic flt);
    @(posedge clock);
    core_req <= '{op: op, fast: fast, pc: pc, status: sv, working_register: sv + 8'h11, bank_select_register: sv + 8'h22};
    @(posedge clock);
    core_req.op <= RAS_OP_NONE;
    @(posedge clock);
    rsp = core_rsp;
    flt = fault_reset;
  endtask
endmodule

/* sim/ras_top_tb.sv */
module ras_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ras_pkg::*;

  logic        clock   = 1'b0;  // 100 ns period
  logic        rst_b;           // power-on reset, falls at time zero so the flops see an edge
  logic        hsel    = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;  // whole words only
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        sys_reset;
  logic        fault_reset;
  logic [15:0] fetch_word;
  ras_req_t    core_req;
  ras_rsp_t    core_rsp;
  ras_fetch_t  fetch_req = '0;
  ras_rsp_t    rsp;             // last sequencer answer
  logic        flt;             // fault request seen with it
  logic [31:0] rdv;             // last bus read data
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #50 clock = ~clock;

  ras_top #(.PM_BYTES(RAS_PM_BYTES)) ras_top_inst (
    .clock(clock), .rst_b(rst_b), .sys_reset(sys_reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_req(core_req),
    .core_rsp(core_rsp), .fetch_req(fetch_req), .fetch_word(fetch_word), .fault_reset(fault_reset));

  ras_seq_model ras_seq_model_inst (
    .clock(clock), .rst_b(rst_b), .fault_reset(fault_reset), .core_rsp(core_rsp),
    .core_req(core_req), .sys_reset(sys_reset));

  // counts, verdict, end of run
  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // compare one value, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait for hready sampled high at an edge; a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= RAS_HTRANS_NSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  // read and compare; the slave never answers other than OKAY
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rdv, exp);
    chk(hresp, 1'b0);
  endtask

  // top entry through its three byte registers
  task automatic rd_tos(input logic [20:0] exp);
    rd(RAS_OFF_TOP_ENTRY_LOW, exp[7:0]);
    rd(RAS_OFF_TOP_ENTRY_HIGH, exp[15:8]);
    rd(RAS_OFF_TOP_ENTRY_UPPER, exp[20:16]);
  endtask

  task automatic op(input ras_op_t o, input logic f, input logic [20:0] pc, input logic [7:0] sv);
    ras_seq_model_inst.do_op(o, f, pc, sv, rsp, flt);
  endtask

  // fetch one word and check what comes back a cycle later
  task automatic fetch(input logic [20:0] a, input logic [15:0] w, input logic [15:0] exp);
    @(posedge clock);
    fetch_req <= '{valid: 1'b1, addr: a, word: w};
    @(posedge clock);
    fetch_req.valid <= 1'b0;
    @(posedge clock);
    chk(fetch_word, exp);
    @(posedge clock);
    chk(fetch_word, 16'h0000);
  endtask

  task automatic t_reset();
    rd(RAS_OFF_PTR, 32'h0);
    rd(RAS_OFF_CFG, 32'h1);
    rd(RAS_OFF_TOP_ENTRY_LOW, 32'h0);
    rd(8'h20, 32'h0);
    $display("reset values done");
  endtask

  // nested calls, software top access, discard and rewrite of the top entry
  task automatic t_push_pop();
    wr(RAS_OFF_CFG, 32'h0);
    op(RAS_OP_CALL, 1'b0, 21'h012346, 8'h0);
    op(RAS_OP_RELATIVE_CALL, 1'b0, 21'h1a5c3e, 8'h0);
    rd(RAS_OFF_PTR, 32'h2);
    rd_tos(21'h1a5c3e);
    op(RAS_OP_POP, 1'b0, 21'h0, 8'h0);
    chk(rsp.pc_valid, 1'b0);
    rd(RAS_OFF_PTR, 32'h1);
    op(RAS_OP_PUSH, 1'b0, 21'h00abcd, 8'h0);
    wr(RAS_OFF_TOP_ENTRY_LOW, 32'h5a);
    op(RAS_OP_RETURN_FROM_INTERRUPT, 1'b0, 21'h0, 8'h0);
    chk({rsp.pc_valid, rsp.pc}, {1'b1, 21'h00ab5a});
    op(RAS_OP_RETURN_WITH_LITERAL, 1'b0, 21'h0, 8'h0);
    chk({rsp.pc_valid, rsp.pc}, {1'b1, 21'h012346});
    rd(RAS_OFF_PTR, 32'h0);
    $display("push and pop done");
  endtask

  // underflow with and without fault reset; flag clearing
  task automatic t_under();
    op(RAS_OP_RETURN, 1'b0, 21'h0, 8'h0);
    chk({rsp.pc_valid, rsp.pc, flt}, {1'b1, 21'h0, 1'b0});
    rd(RAS_OFF_PTR, 32'h40);
    wr(RAS_OFF_PTR, 32'h0);
    rd(RAS_OFF_PTR, 32'h0);
    wr(RAS_OFF_CFG, 32'h1);
    op(RAS_OP_POP, 1'b0, 21'h0, 8'h0);
    chk(flt, 1'b1);
    wr(RAS_OFF_PTR, 32'he0);
    rd(RAS_OFF_PTR, 32'h40);
    wr(RAS_OFF_PTR, 32'h0);
    $display("underflow done");
  endtask

  // fill with fault reset off: pointer sticks at 31, top overwritten
  task automatic t_full_off();
    wr(RAS_OFF_CFG, 32'h0);
    for (int i = 1; i <= 30; i++) begin
      op(RAS_OP_CALL, 1'b0, 21'(i * 4), 8'h0);
    end
    rd(RAS_OFF_PTR, 32'h1e);
    op(RAS_OP_CALL, 1'b0, 21'h0001f0, 8'h0);
    rd(RAS_OFF_PTR, 32'h9f);
    op(RAS_OP_INT_ACK, 1'b0, 21'h1f0e2c, 8'h0);
    chk(flt, 1'b0);
    rd(RAS_OFF_PTR, 32'h9f);
    rd_tos(21'h1f0e2c);
    wr(RAS_OFF_PTR, 32'h0);
    $display("full without reset done");
  endtask

  // 31st push with fault reset on, then a power-on reset
  task automatic t_full_on();
    wr(RAS_OFF_CFG, 32'h1);
    wr(RAS_OFF_PTR, 32'h1e);
    op(RAS_OP_CALL, 1'b0, 21'h012340, 8'h0);
    chk(flt, 1'b1);
    rd(RAS_OFF_PTR, 32'h80);
    wr(RAS_OFF_PTR, 32'hdf);
    rd_tos(21'h012340 + 21'h000002);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(RAS_OFF_PTR, 32'h0);
    $display("full with reset done");
  endtask

  // shadow: nested interrupts overwrite, fast call loads, return_with_literal ignores
  task automatic t_shadow();
    op(RAS_OP_INT_ACK, 1'b0, 21'h000100, 8'h10);
    op(RAS_OP_INT_ACK, 1'b0, 21'h000200, 8'h30);
    op(RAS_OP_RETURN_FROM_INTERRUPT, 1'b1, 21'h0, 8'h0);
    chk({rsp.restore_valid, rsp.status, rsp.working_register, rsp.bank_select_register}, {1'b1, 8'h30, 8'h41, 8'h52});
    op(RAS_OP_CALL, 1'b1, 21'h000300, 8'h60);
    op(RAS_OP_RETURN, 1'b1, 21'h0, 8'h0);
    chk({rsp.restore_valid, rsp.status, rsp.working_register, rsp.bank_select_register}, {1'b1, 8'h60, 8'h71, 8'h82});
    op(RAS_OP_RETURN_WITH_LITERAL, 1'b1, 21'h0, 8'h0);
    chk({rsp.restore_valid, rsp.pc}, {1'b0, 21'h000100});
    $display("shadow done");
  endtask

  task automatic t_fetch();
    fetch(21'(RAS_PM_BYTES - 2), 16'hc3a5, 16'hc3a5);
    fetch(21'(RAS_PM_BYTES), 16'hc3a5, 16'h0);
    fetch(21'h1ffffe, 16'h5a3c, 16'h0);
    $display("fetch done");
  endtask

  // main sequence
  initial begin
    rst_b <= 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_push_pop();
    t_under();
    t_full_off();
    t_full_on();
    t_shadow();
    t_fetch();
    test_done();
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    test_done();
  end
endmodule
